// ===== verilog/adc_control_registers.sv
// Control, status and result registers of an 8-bit multiplexed converter
`timescale 1ns/1ps

module adc_control_registers
(
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  // Register port
  input  wire adc_ctrl_pkg::reg_req_t  req,
  output logic [7:0]                   rdata_q,
  // Interrupt
  output logic                         irq,
  // Crystal clock pin, sampled
  input  wire logic                    crystal_clock,
  // Digitised pin levels of the fifteen channels
  input  wire logic [14:0][7:0]        pin_level,
  // Converter state towards the pins
  output logic [4:0]                   selected_analog_input,
  output logic                         converter_powered,
  output logic                         conversion_busy
);

  adc_ctrl_pkg::status_control_t scr_q;
  adc_ctrl_pkg::clock_cfg_t      clk_cfg_q;
  logic [7:0]                    result_q;
  logic [7:0]                    evt_status_q;
  logic [7:0]                    evt_mask_q;
  logic                          conv_irq_q;
  logic                          unread_q;
  logic [2:0]                    xtal_sync_q;
  logic [14:0][7:0]              pin_s1_q;
  logic [14:0][7:0]              pin_s2_q;
  logic [3:0]                    div_cnt_q;
  logic                          busy_q;
  logic [4:0]                    tick_cnt_q;
  logic [7:0]                    sample_q;
  logic [7:0]                    sar_q;
  logic [7:0]                    sar_d;
  logic                          in_tick;
  logic                          adc_tick;
  logic                          done_pulse;
  logic                          scr_wr;
  logic                          result_rd;
  logic                          powered_off;
  logic                          start;
  logic [7:0]                    channel_code;

  // Divide ratio minus one for a prescaler code
  function automatic logic [3:0] div_limit(input logic [2:0] code);
    unique case (code)
      3'h0:    div_limit = 4'h0;
      3'h1:    div_limit = 4'h1;
      3'h2:    div_limit = 4'h3;
      3'h3:    div_limit = 4'h7;
      default: div_limit = 4'hf;
    endcase
  endfunction

  assign scr_wr      = req.wr && (req.addr == adc_ctrl_pkg::REG_STATUS_CONTROL);
  assign result_rd   = req.rd && (req.addr == adc_ctrl_pkg::REG_RESULT);
  assign powered_off = (scr_q.channel_select == adc_ctrl_pkg::CHAN_POWER_OFF);
  assign start       = scr_wr && (req.wdata[4:0] != adc_ctrl_pkg::CHAN_POWER_OFF);

  // Crystal clock is asynchronous; the edge detector compares the second and third stages
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      xtal_sync_q <= 3'h0;
    else
      xtal_sync_q <= {xtal_sync_q[1:0], crystal_clock};
  end

  // Pin levels come from outside; whole words are held by the converter during the sample
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end
    else
    begin
      pin_s1_q <= pin_level;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign in_tick = (clk_cfg_q.clock_source_select == adc_ctrl_pkg::SRC_BUS) ? 1'b1
                 : (xtal_sync_q[1] && !xtal_sync_q[2]);

  // prescaler; restarts at each start so a conversion spans whole clocks
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      div_cnt_q <= 4'h0;
    else if (start)
      div_cnt_q <= 4'h0;
    else if (in_tick)
      div_cnt_q <= (div_cnt_q >= div_limit(clk_cfg_q.clock_prescaler)) ? 4'h0
                 : div_cnt_q + 4'h1;
  end

  assign adc_tick = in_tick && (div_cnt_q >= div_limit(clk_cfg_q.clock_prescaler));

  // pin channels, reference nodes, unused codes
  always_comb
  begin
    if (scr_q.channel_select <= adc_ctrl_pkg::CHAN_LAST_PIN)
      channel_code = pin_s2_q[scr_q.channel_select[3:0]];
    else if (scr_q.channel_select == adc_ctrl_pkg::CHAN_HIGH_REF)
      channel_code = adc_ctrl_pkg::CODE_HIGH_REF;
    else if (scr_q.channel_select == adc_ctrl_pkg::CHAN_LOW_REF)
      channel_code = adc_ctrl_pkg::CODE_LOW_REF;
    else
      channel_code = adc_ctrl_pkg::CODE_UNUSED;
  end

  // sample at tick 0, then one trial bit per converter clock, MSB first
  always_comb
  begin
    sar_d = sar_q;
    if ((tick_cnt_q != 5'h0) && (tick_cnt_q <= {1'b0, adc_ctrl_pkg::SAR_STEPS}))
    begin
      sar_d[3'({1'b0, adc_ctrl_pkg::SAR_STEPS} - tick_cnt_q)] = 1'b1;
      if (sample_q < sar_d)
        sar_d[3'({1'b0, adc_ctrl_pkg::SAR_STEPS} - tick_cnt_q)] = 1'b0;
    end
  end

  // sixteen full converter clocks, the divider restarts with the start
  assign done_pulse = busy_q && adc_tick && (tick_cnt_q == adc_ctrl_pkg::CONV_TICKS - 5'h1);

  // Converter sequencing
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      busy_q     <= 1'b0;
      tick_cnt_q <= 5'h0;
      sar_q      <= 8'h00;
      sample_q   <= 8'h00;
    end
    else if (start)
    begin
      busy_q     <= 1'b1;
      tick_cnt_q <= 5'h0;
      sar_q      <= 8'h00;
      sample_q   <= 8'h00;
    end
    // Power-off write aborts in the same cycle as the field changes
    else if (powered_off || scr_wr)
      busy_q <= 1'b0;
    else if (!busy_q)
      sample_q <= channel_code;
    else if (adc_tick)
    begin
      sar_q      <= sar_d;
      tick_cnt_q <= tick_cnt_q + 5'h1;
      if (tick_cnt_q == 5'h0)
        sample_q <= channel_code;
      if (done_pulse)
      begin
        busy_q     <= scr_q.continuous_convert;
        tick_cnt_q <= 5'h0;
        sar_q      <= 8'h00;
      end
    end
  end

  // load at completion; overwrite even if unread
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      result_q <= 8'h00;
    else if (done_pulse)
      result_q <= sar_d;
  end

  // Status/control register; reset powers off
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      scr_q <= adc_ctrl_pkg::STATUS_CONTROL_RESET;
    else
    begin
      if (scr_wr)
      begin
        scr_q.conv_irq_enable    <= req.wdata[6];
        scr_q.continuous_convert <= req.wdata[5];
        scr_q.channel_select     <= req.wdata[4:0];
      end
      // completion sets while interrupts are disabled, set wins over clear
      if (done_pulse && !scr_q.conv_irq_enable)
        scr_q.conversion_done_flag <= 1'b1;
      // plain bit once interrupts are enabled
      else if (scr_wr && req.wdata[6])
        scr_q.conversion_done_flag <= req.wdata[7];
      // cleared by write, or by result read while interrupts are disabled
      else if (scr_wr || (result_rd && !scr_q.conv_irq_enable))
        scr_q.conversion_done_flag <= 1'b0;
    end
  end

  // Clock register; reset picks crystal
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      clk_cfg_q <= adc_ctrl_pkg::CLOCK_CFG_RESET;
    else if (req.wr && (req.addr == adc_ctrl_pkg::REG_CLOCK_SELECT))
      clk_cfg_q <= {req.wdata[7:4], 4'h0};
  end

  // request at completion; dropped by result read or status/control write, completion wins
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      conv_irq_q <= 1'b0;
    else if (done_pulse && scr_q.conv_irq_enable)
      conv_irq_q <= 1'b1;
    else if (result_rd || scr_wr)
      conv_irq_q <= 1'b0;
  end

  // Unread result tracking for the overrun event
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      unread_q <= 1'b0;
    else if (done_pulse)
      unread_q <= 1'b1;
    else if (result_rd)
      unread_q <= 1'b0;
  end

  // Sticky events, write one to clear, set wins
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      evt_status_q <= adc_ctrl_pkg::EVENT_RESET;
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (req.wr && (req.addr == adc_ctrl_pkg::REG_EVENT_STATUS) && req.wdata[i])
          evt_status_q[i] <= 1'b0;
      end
      if (done_pulse)
        evt_status_q[adc_ctrl_pkg::EVT_DONE] <= 1'b1;
      if (done_pulse && unread_q && !result_rd)
        evt_status_q[adc_ctrl_pkg::EVT_OVERRUN] <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      evt_mask_q <= adc_ctrl_pkg::EVENT_RESET;
    else if (req.wr && (req.addr == adc_ctrl_pkg::REG_EVENT_MASK))
      evt_mask_q <= req.wdata;
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      rdata_q <= 8'h00;
    else if (req.rd)
    begin
      unique case (req.addr)
        adc_ctrl_pkg::REG_STATUS_CONTROL: rdata_q <= scr_q;
        adc_ctrl_pkg::REG_RESULT:         rdata_q <= result_q;
        adc_ctrl_pkg::REG_CLOCK_SELECT:   rdata_q <= clk_cfg_q;
        adc_ctrl_pkg::REG_EVENT_STATUS:   rdata_q <= evt_status_q;
        adc_ctrl_pkg::REG_EVENT_MASK:     rdata_q <= evt_mask_q;
        default:                          rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  assign irq                   = conv_irq_q || |(evt_status_q & evt_mask_q);
  assign selected_analog_input = scr_q.channel_select;
  assign converter_powered     = !powered_off;
  assign conversion_busy       = busy_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  reset_state_a: assert property ($past(!rst_n) |-> scr_q == 8'h1f && clk_cfg_q == 8'h00)
    else $error("status/control or clock register wrong after reset");
  flag_set_a: assert property (done_pulse && !scr_q.conv_irq_enable |=> scr_q.conversion_done_flag)
    else $error("done flag not set at completion");
  flag_clear_a: assert property (result_rd && !done_pulse && !scr_q.conv_irq_enable
    |=> !scr_q.conversion_done_flag)
    else $error("done flag not cleared by result read");
  flag_rw_a: assert property (scr_wr && req.wdata[6] && !done_pulse
    |=> scr_q.conversion_done_flag == $past(req.wdata[7]))
    else $error("done flag did not take written value");
  irq_raise_a: assert property (done_pulse && scr_q.conv_irq_enable |=> conv_irq_q && irq)
    else $error("interrupt not raised after completion");
  irq_drop_a: assert property ((result_rd || scr_wr) && !done_pulse |=> !conv_irq_q)
    else $error("converter request not dropped");
  start_conv_a: assert property (start |=> busy_q && tick_cnt_q == 5'h0)
    else $error("write did not start a conversion");
  conv_len_a: assert property (done_pulse |-> tick_cnt_q == 5'hf && adc_tick)
    else $error("conversion length is not sixteen converter clocks");
  power_off_a: assert property (powered_off |-> !busy_q && !converter_powered)
    else $error("converter runs while powered off");
  result_load_a: assert property (done_pulse |=> result_q == $past(sar_d))
    else $error("result not loaded at completion");
  single_stop_a: assert property (done_pulse && !scr_q.continuous_convert && !start
    |=> !busy_q)
    else $error("single conversion did not stop");
  cont_go_a: assert property (done_pulse && scr_q.continuous_convert && !scr_wr
    |=> busy_q)
    else $error("continuous conversion stopped");
  high_ref_a: assert property (busy_q && scr_q.channel_select == 5'h1d && tick_cnt_q == 5'h1
    |-> sample_q == 8'hff)
    else $error("high reference not converted as full scale");
  bus_div_a: assert property (clk_cfg_q.clock_source_select && clk_cfg_q.clock_prescaler == 3'h0
    |-> adc_tick)
    else $error("divide by one does not tick every cycle");

  single_cov: cover property (start ##[1:40] done_pulse);
  cont_cov: cover property (done_pulse && scr_q.continuous_convert ##[1:40] done_pulse);
  irq_cov: cover property (conv_irq_q ##1 result_rd);
  overrun_cov: cover property ($rose(evt_status_q[adc_ctrl_pkg::EVT_OVERRUN]));

endmodule

// ===== verilog/adc_ctrl_pkg.sv
// Register map, field layouts and timing constants of the converter control block
package adc_ctrl_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] REG_STATUS_CONTROL = 3'h0;
  localparam logic [2:0] REG_RESULT         = 3'h1;
  localparam logic [2:0] REG_CLOCK_SELECT   = 3'h2;
  localparam logic [2:0] REG_EVENT_STATUS   = 3'h3;
  localparam logic [2:0] REG_EVENT_MASK     = 3'h4;

  // Channel codes
  localparam logic [4:0] CHAN_LAST_PIN  = 5'h0e;
  localparam logic [4:0] CHAN_HIGH_REF  = 5'h1d;
  localparam logic [4:0] CHAN_LOW_REF   = 5'h1e;
  localparam logic [4:0] CHAN_POWER_OFF = 5'h1f;
  localparam int         NUM_PINS       = 15;

  // Converted codes of the internal reference nodes and of unused codes
  localparam logic [7:0] CODE_HIGH_REF  = 8'hff;
  localparam logic [7:0] CODE_LOW_REF   = 8'h00;
  localparam logic [7:0] CODE_UNUSED    = 8'h00;

  // Converter clocks per conversion, counted from the start
  localparam logic [4:0] CONV_TICKS     = 5'h10;
  localparam logic [3:0] SAR_STEPS      = 4'h8;

  // Clock source codes
  localparam logic       SRC_CRYSTAL    = 1'b0;
  localparam logic       SRC_BUS        = 1'b1;

  // Event status bit positions
  localparam int EVT_DONE    = 0;
  localparam int EVT_OVERRUN = 1;

  typedef struct packed {
    logic       conversion_done_flag;
    logic       conv_irq_enable;
    logic       continuous_convert;
    logic [4:0] channel_select;
  } status_control_t;

  typedef struct packed {
    logic [2:0] clock_prescaler;
    logic       clock_source_select;
    logic [3:0] reserved;
  } clock_cfg_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  localparam status_control_t STATUS_CONTROL_RESET = '{1'b0, 1'b0, 1'b0, 5'h1f};
  localparam clock_cfg_t      CLOCK_CFG_RESET      = '{3'h0, 1'b0, 4'h0};
  localparam logic [7:0]      EVENT_RESET          = 8'h00;

endpackage

// ===== verif/analog_inputs_model.sv
// Model of the analog pins and the free-running crystal clock
`timescale 1ns/1ps
module analog_inputs_model
(
  // Level pattern XORed onto every pin by the bench
  input  wire logic [7:0]  bias,
  // Towards the converter
  output logic [14:0][7:0] pin_level,
  output logic             crystal_clock
);
  // Crystal free-running, phase unrelated to the bus clock
  initial crystal_clock = 1'b0;
  always #23 crystal_clock = ~crystal_clock;

  // Distinct level per pin so a wrong mux code shows
  always_comb
  begin
    for (int i = 0; i < 15; i++)
      pin_level[i] = 8'(i * 16 + 3) ^ bias;
  end
endmodule

// ===== verif/tb_adc_control_registers.sv
// Register-level testbench of the converter control block
`timescale 1ns/1ps
module tb_adc_control_registers;
  logic                   ref_clk = 1'b0;
  logic                   rst_n   = 1'b0;
  adc_ctrl_pkg::reg_req_t req     = '0;
  logic [7:0]             bias    = 8'h00;
  logic [7:0]             rdata_q;
  logic [7:0]             d;
  logic                   irq;
  logic                   crystal_clock;
  logic                   converter_powered;
  logic                   conversion_busy;
  logic [14:0][7:0]       pin_level;
  logic [4:0]             selected_analog_input;
  logic [7:0]             codes[4] = '{8'h1d, 8'h1e, 8'h0f, 8'h1c};
  logic [7:0]             vals[4]  = '{adc_ctrl_pkg::CODE_HIGH_REF, adc_ctrl_pkg::CODE_LOW_REF,
                                       adc_ctrl_pkg::CODE_UNUSED, adc_ctrl_pkg::CODE_UNUSED};
  int                     err_total = 0;
  int                     n_checks  = 0;
  int                     n;
  int                     div;

  always #5 ref_clk = ~ref_clk;

  analog_inputs_model partner
  (
    .bias          (bias),
    .pin_level     (pin_level),
    .crystal_clock (crystal_clock)
  );

  adc_control_registers DUT
  (
    .ref_clk               (ref_clk),
    .rst_n                 (rst_n),
    .req                   (req),
    .rdata_q               (rdata_q),
    .irq                   (irq),
    .crystal_clock         (crystal_clock),
    .pin_level             (pin_level),
    .selected_analog_input (selected_analog_input),
    .converter_powered     (converter_powered),
    .conversion_busy       (conversion_busy)
  );

  function automatic logic [7:0] pin_code(input int c);
    return 8'(c * 16 + 3) ^ bias;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge ref_clk);
    req <= '0;
    #1;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    req <= '0;
    #1 d = rdata_q;
    check(d, exp);
  endtask

  // Bounded wait; n ends as edges seen while busy
  task automatic wait_idle();
    n = 0;
    while (conversion_busy !== 1'b0 && n < 2000)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #300us;
    err_total++;
    report_and_stop();
  end

  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk(adc_ctrl_pkg::REG_STATUS_CONTROL, 8'h1f);
    rd_chk(adc_ctrl_pkg::REG_RESULT, 8'h00);
    rd_chk(adc_ctrl_pkg::REG_CLOCK_SELECT, 8'h00);
    rd_chk(3'h7, 8'h00);
    check({7'h0, converter_powered}, 8'h00);
    check({7'h0, irq}, 8'h00);
    $display("test reset done");

    // bus clock source; converter clock scaled with the bench clock
    wr(adc_ctrl_pkg::REG_CLOCK_SELECT, 8'h10);
    wr(adc_ctrl_pkg::REG_STATUS_CONTROL, 8'h00);
    wait_idle();
    for (int c = 0; c < 15; c++)
    begin
      wr(adc_ctrl_pkg::REG_STATUS_CONTROL, 8'(c));
      check({3'h0, selected_analog_input}, 8'(c));
      wait_idle();
      rd_chk(adc_ctrl_pkg::REG_STATUS_CONTROL, 8'h80 | 8'(c));
      rd_chk(adc_ctrl_pkg::REG_RESULT, pin_code(c));
      rd_chk(adc_ctrl_pkg::REG_STATUS_CONTROL, 8'(c));
    end
    foreach (codes[k])
    begin
      wr(adc_ctrl_pkg::REG_STATUS_CONTROL, codes[k]);
      wait_idle();
      rd_chk(adc_ctrl_pkg::REG_RESULT, vals[k]);
    end
    $display("test channels done");

    for (int p = 0; p < 8; p++)
    begin
      wr(adc_ctrl_pkg::REG_CLOCK_SELECT, {3'(p), 5'h10});
      rd_chk(adc_ctrl_pkg::REG_CLOCK_SELECT, {3'(p), 5'h10});
      wr(adc_ctrl_pkg::REG_STATUS_CONTROL, 8'h03);
      wait_idle();
      div = (p > 3) ? 16 : (1 << p);
      check({7'h0, n >= 16 * div && n <= 17 * div + 1}, 8'h01);
      rd_chk(adc_ctrl_pkg::REG_RESULT, pin_code(3));
    end
    wr(adc_ctrl_pkg::REG_CLOCK_SELECT, 8'h00);
    wr(adc_ctrl_pkg::REG_STATUS_CONTROL, 8'h02);
    wait_idle();
    check({7'h0, n >= 64 && n < 2000}, 8'h01);
    rd_chk(adc_ctrl_pkg::REG_STATUS_CONTROL, 8'h82);
    $display("test clocks done");

    wr(adc_ctrl_pkg::REG_CLOCK_SELECT, 8'h10);
    wr(adc_ctrl_pkg::REG_STATUS_CONTROL, 8'hc5);
    wait_idle();
    check({7'h0, irq}, 8'h01);
    rd_chk(adc_ctrl_pkg::REG_STATUS_CONTROL, 8'hc5);
    rd_chk(adc_ctrl_pkg::REG_RESULT, pin_code(5));
    check({7'h0, irq}, 8'h00);
    wr(adc_ctrl_pkg::REG_STATUS_CONTROL, 8'h45);
    wait_idle();
    check({7'h0, irq}, 8'h01);
    rd_chk(adc_ctrl_pkg::REG_STATUS_CONTROL, 8'h45);
    wr(adc_ctrl_pkg::REG_STATUS_CONTROL, 8'h1f);
    check({7'h0, irq}, 8'h00);
    check({6'h0, converter_powered, conversion_busy}, 8'h00);
    rd_chk(adc_ctrl_pkg::REG_RESULT, pin_code(5));
    wr(adc_ctrl_pkg::REG_EVENT_STATUS, 8'hff);
    wr(adc_ctrl_pkg::REG_EVENT_MASK, 8'h01);
    wr(adc_ctrl_pkg::REG_STATUS_CONTROL, 8'h06);
    wait_idle();
    check({7'h0, irq}, 8'h01);
    rd_chk(adc_ctrl_pkg::REG_EVENT_STATUS, 8'h01);
    wr(adc_ctrl_pkg::REG_EVENT_STATUS, 8'h01);
    check({7'h0, irq}, 8'h00);
    wr(adc_ctrl_pkg::REG_EVENT_MASK, 8'h00);
    $display("test interrupt done");

    wr(adc_ctrl_pkg::REG_STATUS_CONTROL, 8'h27);
    repeat (20) @(posedge ref_clk);
    bias <= 8'h5a;
    repeat (60) @(posedge ref_clk);
    rd_chk(adc_ctrl_pkg::REG_RESULT, pin_code(7));
    rd_chk(adc_ctrl_pkg::REG_EVENT_STATUS, 8'h03);
    wr(adc_ctrl_pkg::REG_STATUS_CONTROL, 8'h07);
    wait_idle();
    repeat (40) @(posedge ref_clk);
    check({7'h0, conversion_busy}, 8'h00);
    rd_chk(adc_ctrl_pkg::REG_STATUS_CONTROL, 8'h87);
    $display("test continuous done");
    report_and_stop();
  end
endmodule
